// [cfd_config_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - general code protect bit 0 applies standard security; 1 leaves segment open
// - general write protect bit 0 blocks writes and erases; 1 allows them
// - protection bits only clear; only bulk erase or powerOn restores them to one
// - switchover bit 1 enables two-speed start-up, 0 disables it
// - slow rc power bit 1 high power and accuracy, 0 low power
// - secondary source bit 1 crystal pins, 0 digital clock input
// - initial oscillator field decodes into eight clock sources
// - switch monitor field: 1x none, 01 switching, 00 switching and monitor
// - secondary power bit 1 high power, 0 low power
// - primary frequency range 11, 10, 01 valid; 00 reserved
// - clock output only when enabled and primary mode is 11 or 00
// - primary mode: 11 off, 10 fast crystal, 01 crystal, 00 external
// - watchdog mode from bits 7,5; software enable only counts in 10
// - window disable 0 windowed; early clear harmless when fully disabled
// - prescale bit 1 gives 1:128, 0 gives 1:32
// - postscale ratio is two to the power of the field
// - reset pin enable makes shared pin a reset, else general input
// - brown-out level: 11 low, 10 middle, 01 high, 00 low-power
// - brown-out mode; software bit only counts in mode 01
// - serial pin map 1 default pins, 0 alternate pins
// - power-up timer bit enables the power-up delay
// - bytes live in configuration space, reached by table access only
module cfd_config_decoder (
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            powerOn,
  input  wire logic [23:0]     tblAddr,
  input  wire logic            tblRead,
  input  wire logic            tblWrite,
  input  wire logic [7:0]      tblWrData,
  input  wire logic            progEntryHv,
  input  wire logic            progEntryLv,
  input  wire logic            bulkErase,
  input  wire logic            soft_watchdog_en,
  input  wire logic            soft_brownout_en,
  input  wire logic            sleepMode,
  input  wire logic            watchdog_clear_op,
  input  wire logic            watchdogWindowOpen,
  input  wire logic            resetPin_n,
  output logic [7:0]           tblRdData,
  output logic                 tblRdValid,
  output logic                 general_code_protect,
  output logic                 general_write_protect,
  output logic                 two_speed_startup_en,
  output logic                 slow_rc_power_sel,
  output logic                 secondaryCrystalEn,
  output logic                 secondary_digital_clock_in,
  output cfd_pkg::cfd_osc_e    initial_osc_sel,
  output logic                 clockSwitchEn,
  output logic                 failSafeMonitorEn,
  output logic                 secondary_power_sel,
  output logic [1:0]           primary_freq_range,
  output logic                 primaryFreqReserved,
  output logic                 clock_output,
  output logic [1:0]           primary_osc_mode,
  output logic [1:0]           watchdog_enable_mode,
  output logic                 watchdogRunning,
  output logic                 windowedWatchdogEn,
  output logic                 windowViolationReset,
  output logic [2:0]           watchdogPrescaleLog2,
  output logic [3:0]           watchdogPostscaleLog2,
  output logic                 reset_pin_en,
  output logic                 shared_input_pin,
  output logic                 masterResetReq,
  output logic [1:0]           brownout_level_sel,
  output logic [1:0]           brownout_enable_mode,
  output logic                 brownoutActive,
  output logic                 serial_pin_map_sel,
  output logic                 powerup_timer_en,
  output logic                 debugEn,
  output logic [1:0]           debug_pin_pair_sel,
  output logic                 debugPairReserved
);

  // ==========================================================
  // configuration storage
  logic [7:0] cfgMem [cfd_pkg::CFD_NUM];
  logic [7:0] next_rdData;
  logic       rdHit;
  logic       progAllowed;

  assign progAllowed = progEntryHv | progEntryLv;

  genvar gi;
  generate
    for (gi = 0; gi < cfd_pkg::CFD_NUM; gi++) begin : g_cell
      logic [7:0] wrVal;
      logic [7:0] keepMask;
      always_comb begin
        keepMask = progEntryHv ? 8'h00 : cfd_pkg::CFD_HV[gi];
        wrVal    = (tblWrData & cfd_pkg::CFD_PROG[gi] & ~cfd_pkg::CFD_CLR[gi])
                 | (tblWrData & cfgMem[gi] & cfd_pkg::CFD_CLR[gi])
                 | cfd_pkg::CFD_ONES[gi];
        wrVal    = (wrVal & ~keepMask) | (cfgMem[gi] & keepMask);
      end
      // nonvolatile: device reset does not touch the cells
      always_ff @(posedge sys_clk) begin
        if (powerOn || bulkErase) begin
          cfgMem[gi] <= cfd_pkg::CFD_ERASED[gi];
        end else if (tblWrite && progAllowed
                     && tblAddr == cfd_pkg::CFD_ADDR[gi]) begin
          cfgMem[gi] <= wrVal;
        end
      end
    end
  endgenerate

  // ==========================================================
  // table read port
  always_comb begin
    next_rdData = 8'h00;
    rdHit       = 1'b0;
    for (int i = 0; i < cfd_pkg::CFD_NUM; i++) begin
      if (tblAddr == cfd_pkg::CFD_ADDR[i]) begin
        next_rdData = cfgMem[i];
        rdHit       = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tblRdData  <= 8'h00;
      tblRdValid <= 1'b0;
    end else begin
      tblRdValid <= tblRead;
      if (tblRead) begin
        tblRdData <= rdHit ? next_rdData : 8'h00;
      end
    end
  end

  // ==========================================================
  // reset-time sampling of static settings
  logic [7:0] gsByte;
  logic [7:0] oselByte;
  logic [7:0] osetByte;
  logic [7:0] wdtByte;
  logic [7:0] porByte;
  logic [7:0] dbgByte;
  logic [1:0] pmodeNow;

  assign gsByte   = cfgMem[cfd_pkg::CFD_GS];
  assign oselByte = cfgMem[cfd_pkg::CFD_OSEL];
  assign osetByte = cfgMem[cfd_pkg::CFD_OSET];
  assign wdtByte  = cfgMem[cfd_pkg::CFD_WDT];
  assign porByte  = cfgMem[cfd_pkg::CFD_POR];
  assign dbgByte  = cfgMem[cfd_pkg::CFD_DBG];
  assign pmodeNow = osetByte[cfd_pkg::CFD_B_PMODE +: 2];

  // segment protection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      general_code_protect  <= ~gsByte[cfd_pkg::CFD_B_GCP];
      general_write_protect <= ~gsByte[cfd_pkg::CFD_B_GWP];
    end
  end

  // oscillator selection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      two_speed_startup_en       <= oselByte[cfd_pkg::CFD_B_TWOSPD];
      slow_rc_power_sel          <= oselByte[cfd_pkg::CFD_B_SLOWRC];
      secondaryCrystalEn         <= oselByte[cfd_pkg::CFD_B_SECSRC];
      secondary_digital_clock_in <= ~oselByte[cfd_pkg::CFD_B_SECSRC];
      initial_osc_sel            <= cfd_pkg::cfd_osc_e'(
                                      oselByte[cfd_pkg::CFD_B_OSC +: 3]);
    end
  end

  // oscillator setup
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clockSwitchEn       <= ~osetByte[cfd_pkg::CFD_B_SWMON + 1];
      failSafeMonitorEn   <= (osetByte[cfd_pkg::CFD_B_SWMON +: 2]
                              == cfd_pkg::CFD_MODE_00);
      secondary_power_sel <= osetByte[cfd_pkg::CFD_B_SECPWR];
      primary_freq_range  <= osetByte[cfd_pkg::CFD_B_FREQ +: 2];
      primaryFreqReserved <= (osetByte[cfd_pkg::CFD_B_FREQ +: 2]
                              == cfd_pkg::CFD_MODE_00);
      primary_osc_mode    <= pmodeNow;
      clock_output        <= osetByte[cfd_pkg::CFD_B_CLKOUT]
                             && (pmodeNow == cfd_pkg::CFD_MODE_11
                                 || pmodeNow == cfd_pkg::CFD_MODE_00);
    end
  end

  // watchdog setup
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      watchdog_enable_mode  <= {wdtByte[cfd_pkg::CFD_B_WDTEN1],
                                wdtByte[cfd_pkg::CFD_B_WDTEN0]};
      windowedWatchdogEn    <= ~wdtByte[cfd_pkg::CFD_B_WIN];
      watchdogPrescaleLog2  <= wdtByte[cfd_pkg::CFD_B_PRE]
                               ? cfd_pkg::CFD_PRE_LOG_HI
                               : cfd_pkg::CFD_PRE_LOG_LO;
      watchdogPostscaleLog2 <= wdtByte[cfd_pkg::CFD_B_POST +: 4];
    end
  end

  // reset and brown-out options
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_pin_en         <= porByte[cfd_pkg::CFD_B_RSTPIN];
      brownout_level_sel   <= porByte[cfd_pkg::CFD_B_BROWNOUT_LEVEL_SEL +: 2];
      serial_pin_map_sel   <= porByte[cfd_pkg::CFD_B_SERIAL];
      powerup_timer_en     <= porByte[cfd_pkg::CFD_B_PWRT];
      brownout_enable_mode <= porByte[cfd_pkg::CFD_B_BROWNOUT_ENABLE_MODE +: 2];
    end
  end

  // debugger options
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      debugEn            <= ~dbgByte[cfd_pkg::CFD_B_DEBUG];
      debug_pin_pair_sel <= dbgByte[cfd_pkg::CFD_B_PAIR +: 2];
      debugPairReserved  <= (dbgByte[cfd_pkg::CFD_B_PAIR +: 2]
                             == cfd_pkg::CFD_MODE_00);
    end
  end

  // ==========================================================
  // run-time gating from held settings
  logic next_wdtRun;
  logic next_borActive;

  always_comb begin
    case (watchdog_enable_mode)
      cfd_pkg::CFD_MODE_11: next_wdtRun = 1'b1;
      cfd_pkg::CFD_MODE_10: next_wdtRun = soft_watchdog_en;
      cfd_pkg::CFD_MODE_01: next_wdtRun = ~sleepMode;
      default:              next_wdtRun = 1'b0;
    endcase
  end

  always_comb begin
    case (brownout_enable_mode)
      cfd_pkg::CFD_MODE_11: next_borActive = 1'b1;
      cfd_pkg::CFD_MODE_10: next_borActive = ~sleepMode;
      cfd_pkg::CFD_MODE_01: next_borActive = soft_brownout_en;
      default:              next_borActive = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      watchdogRunning      <= 1'b0;
      brownoutActive       <= 1'b0;
      windowViolationReset <= 1'b0;
    end else begin
      watchdogRunning      <= next_wdtRun;
      brownoutActive       <= next_borActive;
      windowViolationReset <= watchdog_clear_op && windowedWatchdogEn
                              && !watchdogWindowOpen && next_wdtRun;
    end
  end

  // shared reset pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shared_input_pin <= 1'b0;
      masterResetReq   <= 1'b0;
    end else begin
      shared_input_pin <= reset_pin_en ? 1'b0 : resetPin_n;
      masterResetReq   <= reset_pin_en & ~resetPin_n;
    end
  end

endmodule // cfd_config_decoder
`default_nettype wire

// [cfd_config_decoder_props.sv]
`timescale 1ns/1ps
`default_nettype none
module cfd_config_decoder_props (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [23:0] tblAddr,
  input wire logic        tblRead,
  input wire logic        tblRdValid,
  input wire logic [7:0]  tblRdData,
  input wire logic        resetPin_n,
  input wire logic        sleepMode,
  input wire logic        soft_watchdog_en,
  input wire logic        soft_brownout_en,
  input wire logic        watchdog_clear_op,
  input wire logic        watchdogWindowOpen,
  input wire logic        reset_pin_en,
  input wire logic        shared_input_pin,
  input wire logic        masterResetReq,
  input wire logic [1:0]  watchdog_enable_mode,
  input wire logic        watchdogRunning,
  input wire logic        windowedWatchdogEn,
  input wire logic        windowViolationReset,
  input wire logic [1:0]  brownout_enable_mode,
  input wire logic        brownoutActive,
  input wire logic        clock_output,
  input wire logic [1:0]  primary_osc_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire [1:0] wm  = watchdog_enable_mode;
  wire [1:0] bm  = brownout_enable_mode;
  wire       hit = tblAddr[23:4] == 20'hF_8000 && !tblAddr[0] && tblAddr[3:1] >= 3'h2;
  wire       wdr = wm == 2'h3 || (wm == 2'h2 && soft_watchdog_en) || (wm == 2'h1 && !sleepMode);
  wire       bor = bm == 2'h3 || (bm == 2'h2 && !sleepMode) || (bm == 2'h1 && soft_brownout_en);
  // ==========================================
  // table access
  a_read_answered: assert property (tblRead |=> tblRdValid)
    else $error("read not answered");
  a_valid_after_read: assert property (tblRdValid |-> $past(tblRead))
    else $error("valid without read");
  a_unmapped_zero: assert property (tblRead && !hit |=> tblRdData == 8'h00)
    else $error("unmapped read not zero");
  // ==========================================
  // decoded outputs
  a_static_hold: assert property (!$past(rst) |->
    $stable({reset_pin_en, wm, bm, primary_osc_mode, clock_output, windowedWatchdogEn}))
    else $error("static output moved");
  a_clock_out_gate: assert property (clock_output |-> primary_osc_mode inside {2'h0, 2'h3})
    else $error("clock output in wrong mode");
  a_reset_pin_req: assert property (!$past(rst) |->
    masterResetReq == $past(reset_pin_en && !resetPin_n))
    else $error("reset request wrong");
  a_shared_pin_in: assert property (!$past(rst) |->
    shared_input_pin == $past(!reset_pin_en && resetPin_n))
    else $error("shared input wrong");
  a_watchdog_run: assert property (!$past(rst) |-> watchdogRunning == $past(wdr))
    else $error("watchdog run wrong");
  a_brownout_run: assert property (!$past(rst) |-> brownoutActive == $past(bor))
    else $error("brownout active wrong");
  a_window_cause: assert property (!$past(rst) |-> windowViolationReset ==
    $past(watchdog_clear_op && windowedWatchdogEn && !watchdogWindowOpen && wdr))
    else $error("window reset wrong");
  c_read: cover property (tblRead ##1 tblRdValid);
  c_master: cover property (masterResetReq);
  c_window: cover property (windowViolationReset);
endmodule // cfd_config_decoder_props
bind cfd_config_decoder cfd_config_decoder_props u_props (.sys_clk, .rst, .tblAddr, .tblRead,
  .tblRdValid, .tblRdData, .resetPin_n, .sleepMode, .soft_watchdog_en, .soft_brownout_en,
  .watchdog_clear_op, .watchdogWindowOpen, .reset_pin_en, .shared_input_pin, .masterResetReq,
  .watchdog_enable_mode, .watchdogRunning, .windowedWatchdogEn, .windowViolationReset,
  .brownout_enable_mode, .brownoutActive, .clock_output, .primary_osc_mode);
`default_nettype wire

// [cfd_pkg.sv]
`default_nettype none
package cfd_pkg;
  // ==========================================================
  // configuration table layout
  localparam int          CFD_NUM          = 6;
  localparam int          CFD_GS           = 0;
  localparam int          CFD_OSEL         = 1;
  localparam int          CFD_OSET         = 2;
  localparam int          CFD_WDT          = 3;
  localparam int          CFD_POR          = 4;
  localparam int          CFD_DBG          = 5;
  localparam logic [23:0] CFD_ADDR [CFD_NUM] = '{
    24'hF8_0004, 24'hF8_0006, 24'hF8_0008,
    24'hF8_000A, 24'hF8_000C, 24'hF8_000E};
  // values after bulk erase
  localparam logic [7:0]  CFD_ERASED [CFD_NUM] = '{
    8'h03, 8'hE1, 8'h3B, 8'hDF, 8'hFB, 8'hE3};
  // writable bits
  localparam logic [7:0]  CFD_PROG [CFD_NUM] = '{
    8'h00, 8'hE7, 8'hFF, 8'hFF, 8'hFB, 8'h83};
  // clear-only bits
  localparam logic [7:0]  CFD_CLR [CFD_NUM] = '{
    8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // unimplemented bits that read as one
  localparam logic [7:0]  CFD_ONES [CFD_NUM] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h60};
  // bits that only high-voltage entry may change
  localparam logic [7:0]  CFD_HV [CFD_NUM] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  // ==========================================================
  // field positions
  localparam int          CFD_B_GCP        = 1;
  localparam int          CFD_B_GWP        = 0;
  localparam int          CFD_B_TWOSPD     = 7;
  localparam int          CFD_B_SLOWRC     = 6;
  localparam int          CFD_B_SECSRC     = 5;
  localparam int          CFD_B_OSC        = 0;
  localparam int          CFD_B_SWMON      = 6;
  localparam int          CFD_B_SECPWR     = 5;
  localparam int          CFD_B_FREQ       = 3;
  localparam int          CFD_B_CLKOUT     = 2;
  localparam int          CFD_B_PMODE      = 0;
  localparam int          CFD_B_WDTEN1     = 7;
  localparam int          CFD_B_WIN        = 6;
  localparam int          CFD_B_WDTEN0     = 5;
  localparam int          CFD_B_PRE        = 4;
  localparam int          CFD_B_POST       = 0;
  localparam int          CFD_B_RSTPIN     = 7;
  localparam int          CFD_B_BROWNOUT_LEVEL_SEL       = 5;
  localparam int          CFD_B_SERIAL     = 4;
  localparam int          CFD_B_PWRT       = 3;
  localparam int          CFD_B_BROWNOUT_ENABLE_MODE      = 0;
  localparam int          CFD_B_DEBUG      = 7;
  localparam int          CFD_B_PAIR       = 0;
  // ==========================================================
  // decoded encodings
  localparam logic [2:0]  CFD_PRE_LOG_HI   = 3'h7;
  localparam logic [2:0]  CFD_PRE_LOG_LO   = 3'h5;
  localparam logic [1:0]  CFD_MODE_11      = 2'h3;
  localparam logic [1:0]  CFD_MODE_10      = 2'h2;
  localparam logic [1:0]  CFD_MODE_01      = 2'h1;
  localparam logic [1:0]  CFD_MODE_00      = 2'h0;
  typedef enum logic [2:0] {
    CFD_OSC_FAST, CFD_OSC_FAST_DIV_PLL, CFD_OSC_PRIMARY, CFD_OSC_PRIMARY_PLL,
    CFD_OSC_SECONDARY, CFD_OSC_SLOW_RC, CFD_OSC_LP_FAST_DIV, CFD_OSC_FAST_DIV
  } cfd_osc_e;
endpackage
`default_nettype wire

// [tb_cfd_config_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_cfd_config_decoder;
  logic sys_clk = 1'h0;
  logic rst, powerOn, tblRead, tblWrite, progEntryHv, progEntryLv, bulkErase, sleepMode;
  logic soft_watchdog_en, soft_brownout_en, watchdog_clear_op, watchdogWindowOpen, resetPin_n;
  logic [23:0] tblAddr;
  logic [7:0]  tblWrData, tblRdData;
  logic [1:0]  primary_freq_range, primary_osc_mode, watchdog_enable_mode, brownout_level_sel;
  logic [1:0]  brownout_enable_mode, debug_pin_pair_sel;
  logic [2:0]  watchdogPrescaleLog2;
  logic [3:0]  watchdogPostscaleLog2;
  logic tblRdValid, general_code_protect, general_write_protect, two_speed_startup_en;
  logic slow_rc_power_sel, secondaryCrystalEn, secondary_digital_clock_in, clockSwitchEn;
  logic failSafeMonitorEn, secondary_power_sel, primaryFreqReserved, clock_output;
  logic watchdogRunning, windowedWatchdogEn, windowViolationReset, reset_pin_en;
  logic shared_input_pin, masterResetReq, brownoutActive, serial_pin_map_sel;
  logic powerup_timer_en, debugEn, debugPairReserved;
  cfd_pkg::cfd_osc_e initial_osc_sel;
  logic [7:0]  sh [cfd_pkg::CFD_NUM];
  logic [7:0]  cur [cfd_pkg::CFD_NUM];
  int          fails = 0;
  int          totalChecks = 0;
  always #4 sys_clk = ~sys_clk;
  cfd_config_decoder uut (.sys_clk, .rst, .powerOn, .tblAddr, .tblRead, .tblWrite, .tblWrData,
    .progEntryHv, .progEntryLv, .bulkErase, .soft_watchdog_en, .soft_brownout_en, .sleepMode,
    .watchdog_clear_op, .watchdogWindowOpen, .resetPin_n, .tblRdData, .tblRdValid,
    .general_code_protect, .general_write_protect, .two_speed_startup_en, .slow_rc_power_sel,
    .secondaryCrystalEn, .secondary_digital_clock_in, .initial_osc_sel, .clockSwitchEn,
    .failSafeMonitorEn, .secondary_power_sel, .primary_freq_range, .primaryFreqReserved,
    .clock_output, .primary_osc_mode, .watchdog_enable_mode, .watchdogRunning,
    .windowedWatchdogEn, .windowViolationReset, .watchdogPrescaleLog2, .watchdogPostscaleLog2,
    .reset_pin_en, .shared_input_pin, .masterResetReq, .brownout_level_sel,
    .brownout_enable_mode, .brownoutActive, .serial_pin_map_sel, .powerup_timer_en, .debugEn,
    .debug_pin_pair_sel, .debugPairReserved);
  // ==========================================
  // access tasks
  task automatic stopTest();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    totalChecks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    int n;
    @(negedge sys_clk) tblRead = 1'h1;
    tblAddr = a;
    @(negedge sys_clk) tblRead = 1'h0;
    for (n = 0; n < 4 && tblRdValid !== 1'h1; n++) @(negedge sys_clk);
    if (n == 4) begin
      fails++;
      stopTest();
    end
    cmp("tblRdData", {8'h00, e}, {8'h00, tblRdData});
  endtask
  task automatic rdAll();
    for (int j = 0; j < cfd_pkg::CFD_NUM; j++) rd(cfd_pkg::CFD_ADDR[j], sh[j]);
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    logic [7:0] v;
    @(negedge sys_clk) tblWrite = 1'h1;
    tblAddr = cfd_pkg::CFD_ADDR[i];
    tblWrData = d;
    @(negedge sys_clk) tblWrite = 1'h0;
    v = (sh[i] & d & cfd_pkg::CFD_CLR[i]) | (d & cfd_pkg::CFD_PROG[i]) | cfd_pkg::CFD_ONES[i];
    if (progEntryHv) sh[i] = v;
    else if (progEntryLv) sh[i] = (v & ~cfd_pkg::CFD_HV[i]) | (sh[i] & cfd_pkg::CFD_HV[i]);
  endtask
  task automatic rstp();
    @(negedge sys_clk) rst = 1'h1;
    repeat (2) @(negedge sys_clk);
    rst = 1'h0;
    cur = sh;
  endtask
  task automatic chk();
    logic [7:0] g, o, f, w, p, d;
    {g, o, f, w, p, d} = {cur[0], cur[1], cur[2], cur[3], cur[4], cur[5]};
    cmp("gs", {~g[1], ~g[0]}, {general_code_protect, general_write_protect});
    cmp("osel", {o[7:5], ~o[5], o[2:0]}, {two_speed_startup_en, slow_rc_power_sel,
      secondaryCrystalEn, secondary_digital_clock_in, initial_osc_sel});
    cmp("osc", {~f[7], f[7:6] == 2'h0, f[5:3], f[4:3] == 2'h0,
      f[2] & (f[1:0] == 2'h3 | f[1:0] == 2'h0), f[1:0]}, {clockSwitchEn, failSafeMonitorEn,
      secondary_power_sel, primary_freq_range, primaryFreqReserved, clock_output, primary_osc_mode});
    cmp("wdt", {w[7], w[5], ~w[6], w[4] ? 3'h7 : 3'h5, w[3:0]}, {watchdog_enable_mode,
      windowedWatchdogEn, watchdogPrescaleLog2, watchdogPostscaleLog2});
    cmp("por", {p[7:5], p[1:0], p[4:3]}, {reset_pin_en, brownout_level_sel,
      brownout_enable_mode, serial_pin_map_sel, powerup_timer_en});
    cmp("dbg", {~d[7], d[1:0], d[1:0] == 2'h0}, {debugEn, debug_pin_pair_sel, debugPairReserved});
  endtask
  // ==========================================
  // test sequence
  initial begin
    {rst, powerOn, tblRead, tblWrite, progEntryHv, progEntryLv, bulkErase} = 7'h60;
    {sleepMode, soft_watchdog_en, soft_brownout_en, watchdog_clear_op} = 4'h0;
    {watchdogWindowOpen, resetPin_n, tblAddr, tblWrData} = {2'h1, 24'h00_0000, 8'h00};
    sh = cfd_pkg::CFD_ERASED;
    repeat (2) @(negedge sys_clk);
    powerOn = 1'h0;
    repeat (10) @(negedge sys_clk);
    rst = 1'h0;
    cur = sh;
    chk();
    rdAll();
    rd(24'hF8_0000, 8'h00);
    rd(24'h00_0006, 8'h00);
    wr(1, 8'h00);
    rd(cfd_pkg::CFD_ADDR[1], 8'hE1);
    progEntryLv = 1'h1;
    wr(0, 8'h02);
    wr(0, 8'h03);
    wr(4, 8'h00);
    rd(cfd_pkg::CFD_ADDR[0], 8'h02);
    rd(cfd_pkg::CFD_ADDR[4], 8'h80);
    chk();
    progEntryLv = 1'h0;
    progEntryHv = 1'h1;
    for (int i = 0; i < 8; i++) begin
      {sleepMode, soft_brownout_en, soft_watchdog_en} = 3'(i);
      {resetPin_n, watchdogWindowOpen, watchdog_clear_op} = {i[1], i[0], 1'h1};
      for (int j = 0; j < cfd_pkg::CFD_NUM; j++) wr(j, 8'(8'h25 * i + 8'h4B * j));
      rstp();
      chk();
      rdAll();
    end
    @(negedge sys_clk) bulkErase = 1'h1;
    @(negedge sys_clk) bulkErase = 1'h0;
    sh = cfd_pkg::CFD_ERASED;
    rdAll();
    rstp();
    chk();
    stopTest();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    stopTest();
  end
endmodule // tb_cfd_config_decoder
`default_nettype wire
